// >>> verilog/opg_gate.sv
/*
 Output pause gating: holds back analog output sample updates while the selected
 pause source is active, resumes per sample clock source, and issues sync pulses
 and start triggers for oversampling output modules.
 Assumes internal chassis signals and the alignment tick share clk; terminal pins,
 the analog comparison event and the external sample clock are asynchronous.
*/
// How it works
// - While the pause is active, no sample clock edge produces a channel update.
// - An update already under way runs to its full length even if pause arrives.
// - While running, the pause level is looked at only on sample edges, so it acts from the next period.
// - With the onboard clock, an update is issued the cycle after the pause clears.
// - With another clock source, after the pause clears a further sample edge is needed.
// - A polarity input chooses whether a high or a low source level means pause.
// - The source select picks any terminal or any internal chassis signal.
// - The analog comparison event can be the source and pauses at the chosen level.
// - Without a shared sync pulse, a start request always issues its own sync pulse.
// - In multi-chassis mode sync pulse and start trigger leave together on the align tick.
// - Every sample update strobes all channel update outputs in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "opg_consts.svh"
module opg_gate #(
	parameter int NPFI = 8,
	parameter int NINT = 4,
	parameter int NCH  = 8,
	parameter int SELW = 4
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic [NPFI-1:0] pfiPins,
	input  wire logic [NINT-1:0] internalSigs,
	input  wire logic            analogCompEvent,
	input  wire logic [SELW-1:0] pauseSrcSel,
	input  wire logic            pauseActiveHigh,
	input  wire logic            onboardClockSel,
	input  wire logic [15:0]     sampleClkDiv,
	input  wire logic            extSampleClk,
	input  wire logic            startReq,
	input  wire logic            stopReq,
	input  wire logic            syncSharedSel,
	input  wire logic            sharedSyncIn,
	input  wire logic            timedStartSel,
	input  wire logic            timeTrigHit,
	input  wire logic            multiChassisSel,
	input  wire logic            chassisAlignTick,
	output logic      [NCH-1:0]  chanUpdate,
	output logic                 updateBusy,
	output logic                 pausedOut,
	output logic                 genRunning,
	output logic                 syncPulseOut,
	output logic                 startTrigOut
);
	localparam int NSRC = NPFI + NINT + 1;

	typedef struct packed {
		opg_pkg::opg_gate_state_t gate;
		logic [`OPG_CNT_W-1:0]    divCnt;
		logic [7:0]               busyCnt;
		logic [NCH-1:0]           upd;
		logic                     extPrev;
		logic                     run;
		logic                     pendSync;
		logic                     pendStart;
		logic                     syncPulse;
		logic                     startTrig;
		logic                     busy;
		logic                     paused;
	} opg_gate_ctl_t;

	opg_gate_ctl_t st_reg;
	opg_gate_ctl_t st_next;

	// ****************************************
	// Input synchronisation
	// ****************************************
	logic [NPFI+1:0] asyncVec;
	logic [NPFI+1:0] syncVec;
	assign asyncVec = {extSampleClk, analogCompEvent, pfiPins};

	opg_sync #(.W(NPFI + 2)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (asyncVec),
		.syncOut (syncVec)
	);

	// ****************************************
	// Pause source selection
	// ****************************************
	function automatic logic pickSource(input logic [NSRC-1:0] srcs, input logic [SELW-1:0] sel);
		pickSource = (int'(sel) < NSRC) ? srcs[sel] : 1'b0;
	endfunction

	logic [NSRC-1:0] srcVec;
	logic            pauseNow;
	logic            extEdge;
	logic            onboardTick;
	logic            sampleEdge;
	logic            startOk;
	logic            alignOk;
	logic            fireUpdate;
	logic [`OPG_CNT_W-1:0] divLast;

	assign srcVec      = {syncVec[NPFI], internalSigs, syncVec[NPFI-1:0]};
	assign pauseNow    = pickSource(srcVec, pauseSrcSel) == pauseActiveHigh;
	assign extEdge     = syncVec[NPFI+1] & ~st_reg.extPrev;
	assign divLast     = (sampleClkDiv == 16'h0000) ? 16'h0000 : sampleClkDiv - 16'h0001;
	assign onboardTick = st_reg.divCnt >= divLast;
	assign sampleEdge  = onboardClockSel ? onboardTick : extEdge;
	assign startOk     = !timedStartSel || timeTrigHit;
	assign alignOk     = !multiChassisSel || chassisAlignTick;

	// ****************************************
	// Gating state machine
	// ****************************************
	always_comb begin
		st_next           = st_reg;
		st_next.extPrev   = syncVec[NPFI+1];
		st_next.syncPulse = 1'b0;
		st_next.startTrig = 1'b0;
		fireUpdate        = 1'b0;

		if (onboardTick || st_reg.gate != opg_pkg::OPG_RUN) begin
			st_next.divCnt = '0;
		end else begin
			st_next.divCnt = st_reg.divCnt + 16'h0001;
		end

		if (st_reg.run) begin
			case (st_reg.gate)
				opg_pkg::OPG_RUN: begin
					if (sampleEdge) begin
						if (pauseNow) begin
							st_next.gate = opg_pkg::OPG_PAUSED;
						end else begin
							fireUpdate = 1'b1;
						end
					end
				end
				opg_pkg::OPG_PAUSED: begin
					if (!pauseNow) begin
						if (onboardClockSel) begin
							fireUpdate     = 1'b1;
							st_next.gate   = opg_pkg::OPG_RUN;
							st_next.divCnt = '0;
						end else begin
							st_next.gate = opg_pkg::OPG_WAIT_EDGE;
						end
					end
				end
				opg_pkg::OPG_WAIT_EDGE: begin
					if (pauseNow) begin
						st_next.gate = opg_pkg::OPG_PAUSED;
					end else if (sampleEdge) begin
						fireUpdate   = 1'b1;
						st_next.gate = opg_pkg::OPG_RUN;
					end
				end
				default: begin
					st_next.gate = opg_pkg::OPG_PAUSED;
				end
			endcase
		end

		// Updates run to completion regardless of pause
		if (fireUpdate) begin
			st_next.busyCnt = 8'(`OPG_UPDATE_CYCLES);
			st_next.upd     = '1;
		end else if (st_reg.busyCnt != 8'h00) begin
			st_next.busyCnt = st_reg.busyCnt - 8'h01;
			st_next.upd     = '0;
		end else begin
			st_next.upd = '0;
		end

		// ****************************************
		// Start and sync pulse issue
		// ****************************************
		if (startReq && !st_reg.run) begin
			st_next.pendStart = 1'b1;
			st_next.pendSync  = !syncSharedSel;
		end
		if (multiChassisSel) begin
			if (chassisAlignTick && st_reg.pendStart && startOk) begin
				st_next.syncPulse = st_reg.pendSync || sharedSyncIn;
				st_next.startTrig = 1'b1;
				st_next.pendSync  = 1'b0;
				st_next.pendStart = 1'b0;
				st_next.run       = 1'b1;
			end
		end else begin
			if (st_reg.pendSync) begin
				st_next.syncPulse = 1'b1;
				st_next.pendSync  = 1'b0;
			end else if (syncSharedSel && sharedSyncIn) begin
				st_next.syncPulse = 1'b1;
			end
			if (st_reg.pendStart && startOk && !st_reg.pendSync) begin
				st_next.startTrig = 1'b1;
				st_next.pendStart = 1'b0;
				st_next.run       = 1'b1;
			end
		end
		if (stopReq) begin
			st_next.run       = 1'b0;
			st_next.pendStart = 1'b0;
			st_next.pendSync  = 1'b0;
			st_next.gate      = opg_pkg::OPG_RUN;
		end

		// Status flags registered so every output leaves a flip-flop
		st_next.busy   = st_next.busyCnt != 8'h00;
		st_next.paused = st_next.gate != opg_pkg::OPG_RUN;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg      <= '0;
			st_reg.gate <= opg_pkg::opg_gate_state_t'(`OPG_STATE_RESET);
		end else begin
			st_reg <= st_next;
		end
	end

	assign chanUpdate   = st_reg.upd;
	assign updateBusy   = st_reg.busy;
	assign pausedOut    = st_reg.paused;
	assign genRunning   = st_reg.run;
	assign syncPulseOut = st_reg.syncPulse;
	assign startTrigOut = st_reg.startTrig;

	// ****************************************
	// Assertions
	// ****************************************
	sequence pauseSeenOnEdge;
		st_reg.run && st_reg.gate == opg_pkg::OPG_RUN && sampleEdge && pauseNow && !stopReq;
	endsequence
	sequence clearOnboard;
		st_reg.run && st_reg.gate == opg_pkg::OPG_PAUSED && !pauseNow && onboardClockSel
			&& !stopReq;
	endsequence
	sequence clearOther;
		st_reg.run && st_reg.gate == opg_pkg::OPG_PAUSED && !pauseNow && !onboardClockSel
			&& !stopReq;
	endsequence

	pause_blocks_a: assert property (@(posedge clk) disable iff (sys_rst)
		pauseSeenOnEdge |=> chanUpdate == '0) else $error("update while paused");
	no_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(updateBusy) |-> updateBusy [*2]) else $error("update cut short");
	edge_eval_a: assert property (@(posedge clk) disable iff (sys_rst)
		pauseSeenOnEdge |=> pausedOut) else $error("pause not taken on edge");
	onboard_resume_a: assert property (@(posedge clk) disable iff (sys_rst)
		clearOnboard |=> chanUpdate == '1 && !pausedOut) else $error("no onboard resume");
	other_resume_a: assert property (@(posedge clk) disable iff (sys_rst)
		clearOther |=> chanUpdate == '0 ##0 st_reg.gate == opg_pkg::OPG_WAIT_EDGE)
		else $error("update on clearing edge");
	wait_edge_a: assert property (@(posedge clk) disable iff (sys_rst)
		st_reg.gate == opg_pkg::OPG_WAIT_EDGE && !sampleEdge && !stopReq
		|=> chanUpdate == '0) else $error("resume without edge");
	all_channels_a: assert property (@(posedge clk) disable iff (sys_rst)
		chanUpdate != '0 |-> chanUpdate == '1) else $error("channels split");
	sw_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		startReq && !genRunning && !syncSharedSel && !multiChassisSel && !stopReq
		|-> ##[1:2] syncPulseOut) else $error("no implicit sync pulse");
	align_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
		multiChassisSel && $past(multiChassisSel) && startTrigOut |-> $past(chassisAlignTick))
		else $error("start not aligned");
	polarity_a: assert property (@(posedge clk) disable iff (sys_rst)
		st_reg.run && st_reg.gate == opg_pkg::OPG_RUN && sampleEdge && !stopReq
		&& int'(pauseSrcSel) < NSRC && srcVec[pauseSrcSel] != pauseActiveHigh
		|=> !pausedOut) else $error("polarity wrong");
endmodule
`default_nettype wire

// >>> verilog/opg_consts.svh
/*
 Holds the offsets-free constants of the output pause gating block: counter width,
 reset values and timing counts. Assumes inclusion by bare name from design files.
*/
`ifndef OPG_CONSTS_SVH
`define OPG_CONSTS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define OPG_CLK_PERIOD_NS   100
`define OPG_UPDATE_TIME_NS  200
`define OPG_UPDATE_CYCLES   ((`OPG_UPDATE_TIME_NS + `OPG_CLK_PERIOD_NS - 1) / `OPG_CLK_PERIOD_NS)
`define OPG_DIV_DEFAULT     16'h000A

// ****************************************
// Reset values and widths
// ****************************************
`define OPG_STATE_RESET     3'h1
`define OPG_CNT_W           16

`endif

// >>> verilog/opg_pkg.sv
/*
 Types shared by the output pause gating design.
 Assumes the constants header is compiled alongside.
*/
package opg_pkg;
	// One-hot gating states
	typedef enum logic [2:0] {
		OPG_RUN       = 3'b001,
		OPG_PAUSED    = 3'b010,
		OPG_WAIT_EDGE = 3'b100
	} opg_gate_state_t;
endpackage

// >>> verilog/opg_sync.sv
/*
 Two flip-flop synchroniser for a vector of asynchronous levels.
 Assumes each bit is an independent level; no bus coherency is given.
*/
`timescale 1ns/10ps
`default_nettype none
module opg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} opg_sync_state_t;

	opg_sync_state_t st_reg;
	opg_sync_state_t st_next;

	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = asyncIn;
		st_next.stage2 = st_reg.stage1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign syncOut = st_reg.stage2;
endmodule
`default_nettype wire

// >>> tb/opg_ext_clk_model.sv
/*
 Far-side model: an external sample clock source for the gating block.
 Assumes clk is the block clock; the made clock stands low while run is low.
*/
`timescale 1ns/10ps
`default_nettype none
module opg_ext_clk_model (
	input  wire logic clk,
	input  wire logic run,
	output logic      extSampleClk
);
	logic [2:0] phaseReg;
	initial begin
		phaseReg = 3'h0;
		extSampleClk = 1'b0;
	end
	// Falling edge keeps the edges away from the block's sampling edge
	always @(negedge clk) begin
		phaseReg <= run ? phaseReg + 3'h1 : 3'h0;
		extSampleClk <= run & phaseReg[2];
	end
endmodule
`default_nettype wire

// >>> tb/test_output_pause_gating.sv
/*
 Self-checking bench for opg_gate: start and sync, pause gating, resume.
 Assumes opg_ext_clk_model supplies the external sample clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_output_pause_gating;
	localparam int NPFI = 8;
	localparam int NINT = 4;
	logic clk = 1'b0, sys_rst = 1'b1, runExt = 1'b0, extSampleClk;
	logic [NPFI-1:0] pfiPins = '0;
	logic [NINT-1:0] internalSigs = '0;
	logic analogCompEvent = 1'b0, pauseActiveHigh = 1'b1, onboardClockSel = 1'b1;
	logic [3:0] pauseSrcSel = 4'h0;
	logic [15:0] sampleClkDiv = 16'h0010;
	logic startReq = 1'b0, stopReq = 1'b0, syncSharedSel = 1'b0, sharedSyncIn = 1'b0;
	logic timedStartSel = 1'b0, timeTrigHit = 1'b0, multiChassisSel = 1'b0;
	logic chassisAlignTick = 1'b0;
	logic [7:0] chanUpdate;
	logic updateBusy, pausedOut, genRunning, syncPulseOut, startTrigOut;
	logic [31:0] cnt;
	int fail_count = 0, num_checks = 0;
	always #50 clk = ~clk;
	opg_ext_clk_model extModel (.clk(clk), .run(runExt), .extSampleClk(extSampleClk));
	opg_gate #(.NPFI(NPFI), .NINT(NINT), .NCH(8), .SELW(4)) DUT (
		.clk(clk), .sys_rst(sys_rst), .pfiPins(pfiPins), .internalSigs(internalSigs),
		.analogCompEvent(analogCompEvent), .pauseSrcSel(pauseSrcSel),
		.pauseActiveHigh(pauseActiveHigh), .onboardClockSel(onboardClockSel),
		.sampleClkDiv(sampleClkDiv), .extSampleClk(extSampleClk), .startReq(startReq),
		.stopReq(stopReq), .syncSharedSel(syncSharedSel), .sharedSyncIn(sharedSyncIn),
		.timedStartSel(timedStartSel), .timeTrigHit(timeTrigHit),
		.multiChassisSel(multiChassisSel), .chassisAlignTick(chassisAlignTick),
		.chanUpdate(chanUpdate), .updateBusy(updateBusy), .pausedOut(pausedOut),
		.genRunning(genRunning), .syncPulseOut(syncPulseOut), .startTrigOut(startTrigOut));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return chanUpdate === 8'hFF;
			1: return syncPulseOut;
			default: return startTrigOut;
		endcase
	endfunction
	task automatic wait_for(input int k, input int n);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(posedge clk);
			#1;
			seen = sig(k) === 1'b1;
		end
		check({31'h0, seen}, 32'h0000_0001);
	endtask
	// Counts strobes; a partial strobe is a mismatch
	task automatic count_updates(input int n, output logic [31:0] c);
		c = 32'h0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (chanUpdate === 8'hFF) c++;
			else check({24'h0, chanUpdate}, 32'h0);
		end
	endtask
	task automatic src(input int idx, input logic v);
		logic [NPFI+NINT:0] all;
		all = '0;
		all[idx] = v;
		@(posedge clk);
		pfiPins <= all[NPFI-1:0];
		internalSigs <= all[NPFI+NINT-1:NPFI];
		analogCompEvent <= all[NPFI+NINT];
		pauseSrcSel <= idx[3:0];
	endtask
	task automatic pulse_start();
		@(posedge clk);
		startReq <= 1'b1;
		@(posedge clk);
		startReq <= 1'b0;
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#(5000 * 100);
		fail_count++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		check({genRunning, syncPulseOut, startTrigOut, chanUpdate}, 32'h0);
		timedStartSel <= 1'b1;
		pulse_start();
		wait_for(1, 8);
		@(posedge clk);
		timeTrigHit <= 1'b1;
		wait_for(2, 8);
		timeTrigHit <= 1'b0;
		check({31'h0, genRunning}, 32'h0000_0001);
		count_updates(64, cnt);
		check(cnt, 32'h4);
		for (int s = 0; s < 3; s++) begin
			for (int p = 0; p < 2; p++) begin
				pauseActiveHigh <= p[0];
				src(s == 0 ? 1 : (s == 1 ? NPFI + 2 : NPFI + NINT), p[0]);
				repeat (18) @(posedge clk);
				count_updates(48, cnt);
				check(cnt, 32'h0);
				check({31'h0, pausedOut}, 32'h0000_0001);
				src(s == 0 ? 1 : (s == 1 ? NPFI + 2 : NPFI + NINT), !p[0]);
				wait_for(0, 6);
				check({31'h0, pausedOut}, 32'h0);
			end
		end
		pauseActiveHigh <= 1'b1;
		wait_for(0, 20);
		src(NPFI, 1'b1);
		#1;
		check({31'h0, updateBusy}, 32'h0000_0001);
		count_updates(40, cnt);
		check(cnt, 32'h0);
		onboardClockSel <= 1'b0;
		runExt <= 1'b1;
		repeat (20) @(posedge clk);
		runExt <= 1'b0;
		src(NPFI, 1'b0);
		count_updates(16, cnt);
		check(cnt, 32'h0);
		check({31'h0, pausedOut}, 32'h0000_0001);
		runExt <= 1'b1;
		wait_for(0, 16);
		check({31'h0, pausedOut}, 32'h0);
		stopReq <= 1'b1;
		@(posedge clk);
		stopReq <= 1'b0;
		multiChassisSel <= 1'b1;
		timedStartSel <= 1'b0;
		#1;
		check({31'h0, genRunning}, 32'h0);
		pulse_start();
		repeat (3) @(posedge clk);
		chassisAlignTick <= 1'b1;
		wait_for(1, 6);
		check({31'h0, startTrigOut}, 32'h0000_0001);
		chassisAlignTick <= 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
